// file: hci_uart_params.svh
// Constants shared by both ends of the host transport link.
// Assumes a 100 MHz sys_clk; bit-rate divisors are derived from it.
`ifndef HCI_UART_PARAMS_SVH
`define HCI_UART_PARAMS_SVH

`define CLK_HZ            100000000
`define DATA_BITS         8
`define STOP_BITS         1
`define DEV_FLOW_OFF_MAX  8
`define HOST_FLOW_OFF_MAX 2
`define RATE_DEFAULT      4'h4
`define RATE_COUNT        10
`define STRAP_UART        1'b0
`define RX_BUF_DEPTH      4

`endif

// file: hci_uart_pkg.sv
// Types shared by both ends of the host transport link.
// Assumes hci_uart_params.svh supplies the numeric constants.
`include "hci_uart_params.svh"
package hci_uart_pkg;
    typedef logic [3:0] rate_sel_t;
    typedef logic [7:0] byte_t;

    // Clocks per bit for each supported rate, rounded to nearest.
    function automatic logic [15:0] bit_div(input rate_sel_t sel);
        int unsigned rate;
        rate = 115200;
        case (sel)
            4'h0: rate = 9600;
            4'h1: rate = 19200;
            4'h2: rate = 38400;
            4'h3: rate = 57600;
            4'h4: rate = 115200;
            4'h5: rate = 230400;
            4'h6: rate = 460800;
            4'h7: rate = 500000;
            4'h8: rate = 921600;
            4'h9: rate = 1000000;
            default: rate = 115200;
        endcase
        return 16'((`CLK_HZ + rate / 2) / rate);
    endfunction
endpackage

// file: hci_link_if.sv
// Pins between the controller end and the host end of the transport.
// Assumes both ends run on the same sys_clk in simulation.
interface hci_link_if;
    logic dev_txd;
    logic host_txd;
    logic dev_rts_b;
    logic host_rts_b;
    logic usb_detach_request_in;
    logic dplus_pullup_control;
    logic transport_select_strap;

    modport device (
        output dev_txd,
        input  host_txd,
        output dev_rts_b,
        input  host_rts_b,
        input  usb_detach_request_in,
        output dplus_pullup_control,
        input  transport_select_strap
    );

    modport host (
        input  dev_txd,
        output host_txd,
        input  dev_rts_b,
        output host_rts_b,
        output usb_detach_request_in,
        input  dplus_pullup_control,
        output transport_select_strap
    );
endinterface

// file: uart_core.sv
// 8N1 serial transmitter/receiver pair with a small receive buffer.
// Assumes the serial input is already synchronised to sys_clk.
`include "hci_uart_params.svh"
module uart_core #(
    parameter int DEPTH = `RX_BUF_DEPTH
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] div,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    input  wire logic [7:0]  tx_data,
    output logic             txd,
    input  wire logic        rxd,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic [7:0]       rx_data,
    output logic [2:0]       rx_level
);
    // The pointers are two bits wide and the count three, so the depth is bounded.
    if (DEPTH < 2 || DEPTH > 4)
    begin
        $error("uart_core: DEPTH must be 2..4");
    end

    // Transmit: start, 8 data LSB first, one stop.
    logic [15:0] tcnt_q;
    logic [3:0]  tbit_q;
    logic [9:0]  tsh_q;
    logic        tbusy_q;
    wire         ttick = (tcnt_q == 16'h0000);
    assign tx_ready = !tbusy_q;
    assign txd      = tsh_q[0];

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tsh_q   <= 10'h3ff;
            tbusy_q <= 1'b0;
            tcnt_q  <= 16'h0000;
            tbit_q  <= 4'h0;
        end
        else if (!tbusy_q)
        begin
            if (tx_valid)
            begin
                tsh_q   <= {1'b1, tx_data, 1'b0};
                tbusy_q <= 1'b1;
                tcnt_q  <= div - 16'h0001;
                tbit_q  <= 4'h9;
            end
        end
        else if (ttick)
        begin
            tsh_q  <= {1'b1, tsh_q[9:1]};
            tcnt_q <= div - 16'h0001;
            tbit_q <= tbit_q - 4'h1;
            if (tbit_q == 4'h0)
                tbusy_q <= 1'b0;
        end
        else
            tcnt_q <= tcnt_q - 16'h0001;
    end

    // Receive: sample mid-bit after a falling edge.
    logic [15:0] rcnt_q;
    logic [3:0]  rbit_q;
    logic [7:0]  rsh_q;
    logic        rbusy_q;
    logic        rdone;
    wire         rtick = (rcnt_q == 16'h0000);
    assign rdone = rbusy_q && rtick && (rbit_q == 4'h9) && rxd;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rbusy_q <= 1'b0;
            rcnt_q  <= 16'h0000;
            rbit_q  <= 4'h0;
            rsh_q   <= 8'h00;
        end
        else if (!rbusy_q)
        begin
            if (!rxd)
            begin
                rbusy_q <= 1'b1;
                rcnt_q  <= {1'b0, div[15:1]};
                rbit_q  <= 4'h0;
            end
        end
        else if (rtick)
        begin
            rcnt_q <= div - 16'h0001;
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q == 4'h0 && rxd)
                rbusy_q <= 1'b0;
            else if (rbit_q >= 4'h1 && rbit_q <= 4'h8)
                rsh_q <= {rxd, rsh_q[7:1]};
            else if (rbit_q == 4'h9)
                rbusy_q <= 1'b0;
        end
        else
            rcnt_q <= rcnt_q - 16'h0001;
    end

    // Receive buffer; a full buffer drops the byte, which flow control prevents.
    logic [7:0] mem_q [DEPTH];
    logic [1:0] wp_q;
    logic [1:0] rp_q;
    logic [2:0] cnt_q;
    wire        push = rdone && (cnt_q != 3'(DEPTH));
    wire        pop  = rx_valid && rx_ready;
    assign rx_valid = (cnt_q != 3'h0);
    assign rx_level = cnt_q;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_q    <= 2'h0;
            rp_q    <= 2'h0;
            cnt_q   <= 3'h0;
        end
        else
        begin
            if (push)
            begin
                mem_q[wp_q] <= rsh_q;
                wp_q        <= (wp_q == 2'(DEPTH - 1)) ? 2'h0 : wp_q + 2'h1;
            end
            if (pop)
                rp_q <= (rp_q == 2'(DEPTH - 1)) ? 2'h0 : rp_q + 2'h1;
            cnt_q <= cnt_q + {2'h0, push} - {2'h0, pop};
        end
    end

    assign rx_data = mem_q[rp_q];
endmodule

// file: hci_dev_end.sv
// Controller end of the host transport: UART with RTS/CTS, strap select,
// USB detach handling and D+ pull-up. Assumes one sys_clk for both ends.
`include "hci_uart_params.svh"
// Behaviour
// - 8 data bits, no parity, 1 stop
// - RTS/CTS pacing in both directions
// - Device sends at most 8 bytes after flow-off
// - Host sends at most 2 bytes after flow-off
// - Ten bit rates derived from system clock
// - Reset rate 115200, later reconfigurable
// - Strap sampled once; zero selects UART
// - Detach input forces USB disconnect
// - Output drives D+ pull-up switch
module hci_dev_end (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    hci_link_if.device                 link,
    input  wire hci_uart_pkg::rate_sel_t rate_sel,
    input  wire logic                  rate_load,
    input  wire logic                  tx_valid,
    output logic                       tx_ready,
    input  wire hci_uart_pkg::byte_t   tx_data,
    output logic                       rx_valid,
    input  wire logic                  rx_ready,
    output hci_uart_pkg::byte_t        rx_data,
    output logic                       uart_selected,
    output logic                       usb_connected
);
    // Two-flop synchronisers for every pin input.
    logic [1:0] rxd_s_q;
    logic [1:0] cts_s_q;
    logic [1:0] det_s_q;
    logic [1:0] strap_s_q;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxd_s_q   <= 2'h3;
            cts_s_q   <= 2'h3;
            det_s_q   <= 2'h0;
            strap_s_q <= 2'h0;
        end
        else
        begin
            rxd_s_q   <= {rxd_s_q[0], link.host_txd};
            cts_s_q   <= {cts_s_q[0], link.host_rts_b};
            det_s_q   <= {det_s_q[0], link.usb_detach_request_in};
            strap_s_q <= {strap_s_q[0], link.transport_select_strap};
        end
    end

    // Strap is captured once, four edges after reset release. The host's strap
    // register also resets to UART, so its real level needs that long to pass
    // the synchroniser.
    logic       strap_done_q;
    logic       strap_q;
    logic [1:0] strap_wait_q;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strap_done_q <= 1'b0;
            strap_q      <= 1'b0;
            strap_wait_q <= 2'h0;
        end
        else if (!strap_done_q)
        begin
            strap_wait_q <= strap_wait_q + 2'h1;
            if (strap_wait_q == 2'h3)
            begin
                strap_q      <= strap_s_q[1];
                strap_done_q <= 1'b1;
            end
        end
    end
    wire uart_on = strap_done_q && (strap_q == `STRAP_UART);
    assign uart_selected = uart_on;

    // USB side: pull-up asserted only when USB chosen and not detached.
    logic pull_q;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            pull_q <= 1'b0;
        else
            pull_q <= strap_done_q && !uart_on && !det_s_q[1];
    end
    assign link.dplus_pullup_control = pull_q;
    assign usb_connected = pull_q;

    // Bit rate register.
    hci_uart_pkg::rate_sel_t rate_q;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            rate_q <= `RATE_DEFAULT;
        else if (rate_load && rate_sel < 4'(`RATE_COUNT))
            rate_q <= rate_sel;
    end
    wire [15:0] div = hci_uart_pkg::bit_div(rate_q);

    // Stop starting new bytes at once when host signals flow-off,
    // well inside the eight-byte allowance.
    wire        host_stop = cts_s_q[1];
    wire        core_tx_ready;
    wire        tx_go = tx_valid && uart_on && !host_stop;
    assign tx_ready = core_tx_ready && uart_on && !host_stop;

    wire [2:0] level;
    wire       core_txd;
    uart_core #(.DEPTH(`RX_BUF_DEPTH)) u_core (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .div      (div),
        .tx_valid (tx_go),
        .tx_ready (core_tx_ready),
        .tx_data  (tx_data),
        .txd      (core_txd),
        .rxd      (rxd_s_q[1]),
        .rx_valid (rx_valid),
        .rx_ready (rx_ready),
        .rx_data  (rx_data),
        .rx_level (level)
    );
    assign link.dev_txd = core_txd;

    // Flow-off once only two free slots remain, so the host's two late
    // bytes always fit.
    logic rts_q;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            rts_q <= 1'b1;
        else
            rts_q <= !uart_on || (level >= 3'(`RX_BUF_DEPTH - `HOST_FLOW_OFF_MAX));
    end
    assign link.dev_rts_b = rts_q;
endmodule

// file: hci_host_end.sv
// Application host end of the transport: UART with RTS/CTS, drives the
// strap and detach sideband. Assumes the same sys_clk as the device.
`include "hci_uart_params.svh"
module hci_host_end (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    hci_link_if.host                   link,
    input  wire hci_uart_pkg::rate_sel_t rate_sel,
    input  wire logic                  use_usb,
    input  wire logic                  detach,
    input  wire logic                  tx_valid,
    output logic                       tx_ready,
    input  wire hci_uart_pkg::byte_t   tx_data,
    output logic                       rx_valid,
    input  wire logic                  rx_ready,
    output hci_uart_pkg::byte_t        rx_data,
    output logic                       pullup_seen
);
    logic [1:0] rxd_s_q;
    logic [1:0] cts_s_q;
    logic [1:0] pu_s_q;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxd_s_q <= 2'h3;
            cts_s_q <= 2'h3;
            pu_s_q  <= 2'h0;
        end
        else
        begin
            rxd_s_q <= {rxd_s_q[0], link.dev_txd};
            cts_s_q <= {cts_s_q[0], link.dev_rts_b};
            pu_s_q  <= {pu_s_q[0], link.dplus_pullup_control};
        end
    end
    assign pullup_seen = pu_s_q[1];

    logic strap_q;
    logic det_q;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strap_q <= `STRAP_UART;
            det_q   <= 1'b0;
        end
        else
        begin
            strap_q <= use_usb ? !`STRAP_UART : `STRAP_UART;
            det_q   <= detach;
        end
    end
    assign link.transport_select_strap = strap_q;
    assign link.usb_detach_request_in  = det_q;

    wire [15:0] div = hci_uart_pkg::bit_div(rate_sel);
    // Starting no new byte once flow-off is seen keeps late bytes at one.
    wire dev_stop = cts_s_q[1];
    wire core_tx_ready;
    wire tx_go = tx_valid && !dev_stop;
    assign tx_ready = core_tx_ready && !dev_stop;

    wire [2:0] level;
    wire       core_txd;
    uart_core #(.DEPTH(`RX_BUF_DEPTH)) u_core (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .div      (div),
        .tx_valid (tx_go),
        .tx_ready (core_tx_ready),
        .tx_data  (tx_data),
        .txd      (core_txd),
        .rxd      (rxd_s_q[1]),
        .rx_valid (rx_valid),
        .rx_ready (rx_ready),
        .rx_data  (rx_data),
        .rx_level (level)
    );
    assign link.host_txd = core_txd;

    logic rts_q;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            rts_q <= 1'b1;
        else
            rts_q <= (level > 3'(`RX_BUF_DEPTH - `HOST_FLOW_OFF_MAX));
    end
    assign link.host_rts_b = rts_q;
endmodule

// file: hci_uart_transport_properties.sv
// Checker for the wire between the controller end and the host end.
// Assumes one sys_clk for both ends and rst_b low while either end resets.
module hci_uart_transport_properties (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic dev_txd,
    input wire logic host_txd,
    input wire logic dev_rts_b,
    input wire logic host_rts_b,
    input wire logic usb_detach_request_in,
    input wire logic dplus_pullup_control,
    input wire logic transport_select_strap
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    // A byte has at most five falling edges, so edges bound the bytes sent after flow-off.
    logic       dev_txd_q;
    logic       host_txd_q;
    logic [5:0] dev_falls_q;
    logic [5:0] host_falls_q;
    logic [5:0] dev_falls_d;
    logic [5:0] host_falls_d;

    assign dev_falls_d = host_rts_b ? dev_falls_q + {5'h00, dev_txd_q & ~dev_txd} : 6'h00;
    assign host_falls_d = dev_rts_b ? host_falls_q + {5'h00, host_txd_q & ~host_txd} : 6'h00;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dev_txd_q <= 1'b1;
            host_txd_q <= 1'b1;
            dev_falls_q <= 6'h00;
            host_falls_q <= 6'h00;
        end
        else
        begin
            dev_txd_q <= dev_txd;
            host_txd_q <= host_txd;
            dev_falls_q <= dev_falls_d;
            host_falls_q <= host_falls_d;
        end
    end

    sequence s_low_run(logic line);
        !line [*8];
    endsequence
    sequence s_detach_held;
        usb_detach_request_in [*6];
    endsequence

    property p_idle_after_reset;
        $rose(rst_b) |-> dev_txd && host_txd && !dplus_pullup_control;
    endproperty
    property p_dev_start_bit;
        $fell(dev_txd) |-> s_low_run(dev_txd);
    endproperty
    property p_host_start_bit;
        $fell(host_txd) |-> s_low_run(host_txd);
    endproperty
    property p_dev_flow_off;
        dev_falls_q <= 6'h28;
    endproperty
    property p_host_flow_off;
        host_falls_q <= 6'h0a;
    endproperty
    property p_detach_drops_pullup;
        s_detach_held |-> !dplus_pullup_control;
    endproperty
    property p_pullup_rise;
        $rose(dplus_pullup_control) |->
            transport_select_strap && !usb_detach_request_in && !$past(usb_detach_request_in, 2);
    endproperty
    property p_usb_mode_quiet;
        transport_select_strap [*8] |-> dev_txd;
    endproperty

    a_idle_after_reset: assert property (p_idle_after_reset)
        else $error("lines not idle high after reset");
    a_dev_start_bit: assert property (p_dev_start_bit)
        else $error("device start bit too short");
    a_host_start_bit: assert property (p_host_start_bit)
        else $error("host start bit too short");
    a_dev_flow_off: assert property (p_dev_flow_off)
        else $error("device kept sending after flow-off");
    a_host_flow_off: assert property (p_host_flow_off)
        else $error("host kept sending after flow-off");
    a_detach_drops_pullup: assert property (p_detach_drops_pullup)
        else $error("pull-up stays on while detach is held");
    a_pullup_rise: assert property (p_pullup_rise)
        else $error("pull-up switched on without usb strap or during detach");
    a_usb_mode_quiet: assert property (p_usb_mode_quiet)
        else $error("serial output active with usb strap");
endmodule

// file: hci_uart_transport_test.sv
// Self-checking bench joining both transport ends through the link interface.
// Assumes the design files are compiled first; index 0 is the device, 1 the host.
module hci_uart_transport_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk;
    logic rst_b;
    hci_uart_pkg::rate_sel_t dev_rate_sel;
    hci_uart_pkg::rate_sel_t host_rate_sel;
    logic rate_load;
    logic use_usb;
    logic detach;
    logic tx_valid [2];
    logic tx_ready [2];
    hci_uart_pkg::byte_t tx_data [2];
    logic rx_valid [2];
    logic rx_ready [2];
    hci_uart_pkg::byte_t rx_data [2];
    logic uart_selected;
    logic usb_connected;
    logic pullup_seen;
    logic line [2];
    logic rts [2];
    hci_uart_pkg::byte_t exp_q [2][$];
    hci_uart_pkg::byte_t wq [2][$];
    int off [2];
    int cur_div;
    logic [7:0] rnd;
    int comparisons;
    int miscompares;

    hci_link_if link ();
    assign line[0] = link.dev_txd;
    assign line[1] = link.host_txd;
    assign rts[0] = link.host_rts_b;
    assign rts[1] = link.dev_rts_b;

    hci_dev_end hci_dev_end_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
        .rate_sel(dev_rate_sel), .rate_load(rate_load), .tx_valid(tx_valid[0]),
        .tx_ready(tx_ready[0]), .tx_data(tx_data[0]), .rx_valid(rx_valid[0]),
        .rx_ready(rx_ready[0]), .rx_data(rx_data[0]), .uart_selected(uart_selected),
        .usb_connected(usb_connected));
    hci_host_end hci_host_end_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
        .rate_sel(host_rate_sel), .use_usb(use_usb), .detach(detach),
        .tx_valid(tx_valid[1]), .tx_ready(tx_ready[1]), .tx_data(tx_data[1]),
        .rx_valid(rx_valid[1]), .rx_ready(rx_ready[1]), .rx_data(rx_data[1]),
        .pullup_seen(pullup_seen));
    hci_uart_transport_properties hci_uart_transport_properties_i (.sys_clk(sys_clk),
        .rst_b(rst_b), .dev_txd(link.dev_txd), .host_txd(link.host_txd),
        .dev_rts_b(link.dev_rts_b), .host_rts_b(link.host_rts_b),
        .usb_detach_request_in(link.usb_detach_request_in),
        .dplus_pullup_control(link.dplus_pullup_control),
        .transport_select_strap(link.transport_select_strap));

    always #5 sys_clk = ~sys_clk;

    function automatic int exp_div(input int i);
        int r [10] = '{9600, 19200, 38400, 57600, 115200, 230400, 460800, 500000, 921600, 1000000};
        return (100000000 + r[i] / 2) / r[i];
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic send(input int s, input hci_uart_pkg::byte_t b);
        int n;
        n = 0;
        tx_valid[s] <= 1'b1;
        tx_data[s] <= b;
        @(negedge sys_clk);
        while (tx_ready[s] !== 1'b1 && n < 60000)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        exp_q[s].push_back(b);
        wq[s].push_back(b);
    endtask

    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic burst(input int s, input int n);
        repeat (n)
        begin
            rnd = lfsr_next(rnd);
            send(s, rnd);
        end
        tx_valid[s] <= 1'b0;
    endtask

    // Waiting for both queues also proves that a stalled receiver lost no byte.
    task automatic drain();
        int n;
        n = 0;
        while (exp_q[0].size() + exp_q[1].size() + wq[0].size() + wq[1].size() > 0 && n < 40000)
        begin
            @(negedge sys_clk);
            n++;
        end
        check("bytes left", 8'h00, 8'(exp_q[0].size() + exp_q[1].size()));
        @(posedge sys_clk);
    endtask

    task automatic pair(input int n);
        fork
            burst(0, n);
            burst(1, n);
        join
        drain();
    endtask

    task automatic watch(input int s);
        hci_uart_pkg::byte_t v;
        @(negedge sys_clk);
        if (rts[s] !== 1'b1)
            off[s] = 0;
        if (line[s] === 1'b0 && rst_b === 1'b1)
        begin
            if (rts[s] === 1'b1)
                off[s]++;
            check("bytes after flow-off", 8'h01, 8'(off[s] <= (s ? 2 : 8)));
            repeat (cur_div / 2) @(negedge sys_clk);
            check("start bit", 8'h00, 8'(line[s]));
            for (int i = 0; i < 8; i++)
            begin
                repeat (cur_div) @(negedge sys_clk);
                v[i] = line[s];
            end
            repeat (cur_div) @(negedge sys_clk);
            check("stop bit", 8'h01, 8'(line[s]));
            check("wire byte", wq[s].size() ? wq[s].pop_front() : 8'hxx, v);
        end
    endtask

    initial forever watch(0);
    initial forever watch(1);

    always @(negedge sys_clk)
        for (int r = 0; r < 2; r++)
            if (rx_valid[r] === 1'b1 && rx_ready[r] === 1'b1)
                check("received byte", exp_q[1 - r].size() ? exp_q[1 - r].pop_front() : 8'hxx,
                      rx_data[r]);

    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (80000) @(posedge sys_clk);
        miscompares++;
        $display("MISMATCH watchdog expected end of tests seen hang");
        final_report();
    end

    initial
    begin
        sys_clk = 1'b0;
        rst_b = 1'b0;
        dev_rate_sel = 4'h4;
        host_rate_sel = 4'h4;
        rate_load = 1'b0;
        use_usb = 1'b0;
        detach = 1'b0;
        rnd = 8'h5f;
        comparisons = 0;
        miscompares = 0;
        cur_div = exp_div(4);
        for (int s = 0; s < 2; s++)
        begin
            tx_valid[s] = 1'b0;
            tx_data[s] = 8'h00;
            rx_ready[s] = 1'b1;
            off[s] = 0;
        end
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (8) @(negedge sys_clk);
        check("uart selected", 8'h01, 8'(uart_selected));
        check("usb connected", 8'h00, 8'(usb_connected));
        check("pull-up seen", 8'h00, 8'(pullup_seen));
        @(posedge sys_clk);
        fork
            send(0, 8'h80);
            send(1, 8'h01);
        join
        tx_valid[0] <= 1'b0;
        tx_valid[1] <= 1'b0;
        drain();
        $display("test default rate done");
        // Index 10 is refused, so its byte must still cross at the previous rate.
        for (int i = 5; i <= 10; i++)
        begin
            dev_rate_sel <= 4'(i);
            rate_load <= 1'b1;
            if (i < 10)
                host_rate_sel <= 4'(i);
            @(posedge sys_clk);
            rate_load <= 1'b0;
            if (i < 10)
                cur_div = exp_div(i);
            pair(1);
        end
        $display("test rate table done");
        rx_ready[0] <= 1'b0;
        rx_ready[1] <= 1'b0;
        fork
            burst(0, 8);
            burst(1, 8);
        join_none
        repeat (8000) @(negedge sys_clk);
        check("device flow-off", 8'h01, 8'(link.dev_rts_b));
        check("host flow-off", 8'h01, 8'(link.host_rts_b));
        @(posedge sys_clk);
        rx_ready[0] <= 1'b1;
        rx_ready[1] <= 1'b1;
        wait fork;
        drain();
        $display("test flow-off done");
        rst_b <= 1'b0;
        use_usb <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        tx_valid[0] <= 1'b1;
        tx_data[0] <= 8'h5a;
        repeat (12) @(negedge sys_clk);
        check("uart selected", 8'h00, 8'(uart_selected));
        check("device tx ready", 8'h00, 8'(tx_ready[0]));
        check("usb connected", 8'h01, 8'(usb_connected));
        check("pull-up seen", 8'h01, 8'(pullup_seen));
        @(posedge sys_clk);
        detach <= 1'b1;
        repeat (12) @(negedge sys_clk);
        check("usb connected", 8'h00, 8'(usb_connected));
        check("pull-up seen", 8'h00, 8'(pullup_seen));
        @(posedge sys_clk);
        detach <= 1'b0;
        tx_valid[0] <= 1'b0;
        repeat (12) @(posedge sys_clk);
        use_usb <= 1'b0;
        repeat (12) @(negedge sys_clk);
        check("uart selected", 8'h00, 8'(uart_selected));
        check("usb connected", 8'h01, 8'(usb_connected));
        $display("test usb strap done");
        final_report();
    end
endmodule
